// *** logic/animator_pkg.sv ***
package animator_pkg;

    // ------------------------------------------------------------
    // Register offsets and storage slots
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_CH1_CMP = 7'h03;
    localparam logic [6:0] ADDR_CH0_CMP = 7'h15;
    localparam logic [6:0] ADDR_SHARED = 7'h1f;
    localparam logic [6:0] ADDR_FLOOR = 7'h20;
    localparam logic [6:0] ADDR_CEIL = 7'h21;
    localparam logic [6:0] ADDR_FREQ = 7'h22;
    localparam logic [6:0] ADDR_RATE = 7'h23;
    localparam logic [6:0] ADDR_FIRST = 7'h24;
    localparam logic [6:0] ADDR_SHWAIT = 7'h25;
    localparam logic [6:0] ADDR_SEQ = 7'h27;
    localparam int NUM_REGS = 10;
    localparam logic [3:0] IDX_NONE = 4'hf;

    // Values after reset, in slot order
    localparam logic [15:0] RST_CH1_CMP = 16'h0400;
    localparam logic [15:0] RST_CH0_CMP = 16'h0407;
    localparam logic [15:0] RST_SHARED = 16'h13f9;
    localparam logic [15:0] RST_FLOOR = 16'h0000;
    localparam logic [15:0] RST_CEIL = 16'hfe00;
    localparam logic [15:0] RST_FREQ = 16'h0000;
    localparam logic [15:0] RST_RATE = 16'h0000;
    localparam logic [15:0] RST_FIRST = 16'h0000;
    localparam logic [15:0] RST_SHWAIT = 16'h0000;
    localparam logic [15:0] RST_SEQ = 16'h0003;

    // Field positions
    localparam int DUTY_LSB = 9;
    localparam int FREQ_LSB = 7;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_NS = 10;
    localparam int STEP_UNIT_NS = 2400;
    localparam int STEP_BASE_NS = 5600;
    localparam int STEP_UNIT_CYC = STEP_UNIT_NS / CLK_NS;
    localparam int STEP_BASE_CYC = STEP_BASE_NS / CLK_NS;
    localparam int RATE_OFF_VALUE = 256;
    localparam int PWM_BASE_PERIOD_NS = 20480;
    localparam int PWM_TICK_CYC = PWM_BASE_PERIOD_NS / (128 * CLK_NS);
    localparam logic [6:0] CODE_FULL = 7'h7f;
    localparam logic [2:0] TRIG_SLOT = 3'h4;
    localparam int SCALE_SHIFT = 5;

    typedef struct packed {
        logic [6:0] floor;
        logic [6:0] ceiling;
        logic [4:0] freq;
        logic [15:0] rate;
        logic [15:0] first_wait;
        logic [15:0] shared_wait;
    } cfg_s;

    // Address to storage slot
    function automatic logic [3:0] reg_index(input logic [6:0] a);
        if (a == ADDR_CH1_CMP) return 4'h0;
        else if (a == ADDR_CH0_CMP) return 4'h1;
        else if (a == ADDR_SHARED) return 4'h2;
        else if (a == ADDR_FLOOR) return 4'h3;
        else if (a == ADDR_CEIL) return 4'h4;
        else if (a == ADDR_FREQ) return 4'h5;
        else if (a == ADDR_RATE) return 4'h6;
        else if (a == ADDR_FIRST) return 4'h7;
        else if (a == ADDR_SHWAIT) return 4'h8;
        else if (a == ADDR_SEQ) return 4'h9;
        else return IDX_NONE;
    endfunction : reg_index

    // PWM tick divider per frequency code; code 31 is off the regular line
    function automatic logic [7:0] freq_div(input logic [4:0] c);
        if (c <= 5'h04) return {3'h0, c};
        else if (c == 5'h05) return 8'h06;
        else if (c == 5'h06) return 8'h08;
        else if (c == 5'h1f) return 8'he0;
        else return 8'({c - 5'h05, 3'h0});
    endfunction : freq_div

    // Cycles in one fade step
    function automatic logic [23:0] step_cycles(input logic [15:0] rate);
        int r;
        r = (rate == 16'h0000) ? RATE_OFF_VALUE : int'(rate);
        return 24'(r * STEP_UNIT_CYC + STEP_BASE_CYC);
    endfunction : step_cycles

endpackage : animator_pkg

// *** logic/config_store.sv ***
module config_store (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [6:0] addr,
    input wire logic [15:0] wdata,
    output logic [15:0] rdata,
    output animator_pkg::cfg_s cfg
);
    logic [15:0] mem_r [animator_pkg::NUM_REGS];
    logic [15:0] rdata_r;
    wire logic [3:0] idx = animator_pkg::reg_index(addr);
    wire logic hit = idx != animator_pkg::IDX_NONE;

    // ------------------------------------------------------------
    // Storage, with reset values per slot
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_r[0] <= animator_pkg::RST_CH1_CMP;
            mem_r[1] <= animator_pkg::RST_CH0_CMP;
            mem_r[2] <= animator_pkg::RST_SHARED;
            mem_r[3] <= animator_pkg::RST_FLOOR;
            mem_r[4] <= animator_pkg::RST_CEIL;
            mem_r[5] <= animator_pkg::RST_FREQ;
            mem_r[6] <= animator_pkg::RST_RATE;
            mem_r[7] <= animator_pkg::RST_FIRST;
            mem_r[8] <= animator_pkg::RST_SHWAIT;
            mem_r[9] <= animator_pkg::RST_SEQ;
        end else if (ce && wr_en && hit) begin
            mem_r[idx] <= wdata;
        end
    end

    // Registered read; unmapped reads return zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= 16'h0000;
        end else if (ce && rd_en) begin
            rdata_r <= hit ? mem_r[idx] : 16'h0000;
        end
    end

    assign rdata = rdata_r;
    assign cfg.floor = mem_r[3][animator_pkg::DUTY_LSB +: 7];
    assign cfg.ceiling = mem_r[4][animator_pkg::DUTY_LSB +: 7];
    assign cfg.freq = mem_r[5][animator_pkg::FREQ_LSB +: 5];
    assign cfg.rate = mem_r[6];
    assign cfg.first_wait = mem_r[7];
    assign cfg.shared_wait = mem_r[8];
endmodule : config_store

// *** logic/fade_channel.sv ***
module fade_channel (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic restart,
    input wire logic go,
    input wire logic step,
    input wire logic fade_on,
    input wire logic freq_ok,
    input wire logic [6:0] floor,
    input wire logic [6:0] ceiling,
    input wire logic [6:0] phase,
    output logic [6:0] duty,
    output logic drive_low
);
    logic [12:0] acc_r;
    logic [12:0] acc_nxt;
    logic [6:0] duty_r;
    logic [6:0] duty_nxt;
    logic active_r;
    logic drive_low_r;

    // ------------------------------------------------------------
    // Logarithmic ramp, value kept scaled by 32
    // ------------------------------------------------------------
    wire logic [6:0] floor_eff = (floor == 7'h00) ? 7'h01 : floor; // [R21]
    wire logic [12:0] grown = acc_r + (acc_r >> animator_pkg::SCALE_SHIFT); // [R05] [R21]
    wire logic [6:0] grown_code = grown[11:5];
    wire logic at_top = grown[12] || (grown_code >= ceiling); // [R19]
    wire logic [6:0] first_code = (floor_eff > ceiling) ? ceiling : floor_eff; // [R20]

    // Next ramp value: restart clears, go loads floor, step grows
    always_comb begin
        acc_nxt = acc_r;
        duty_nxt = duty_r;
        if (restart) begin
            acc_nxt = 13'h0000;
            duty_nxt = 7'h00;
        end else if (go) begin
            acc_nxt = {1'b0, floor_eff, 5'h00};
            duty_nxt = fade_on ? first_code : ceiling; // [R04] [R17]
        end else if (step && active_r && fade_on && !at_top) begin
            acc_nxt = grown; // [R05] [R18]
            duty_nxt = grown_code;
        end else if (step && active_r && fade_on) begin
            duty_nxt = ceiling;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acc_r <= 13'h0000;
            duty_r <= 7'h00;
            active_r <= 1'b0;
        end else if (ce) begin
            acc_r <= acc_nxt;
            duty_r <= duty_nxt;
            active_r <= !restart && (go || active_r);
        end
    end

    // Compare: 0 is always low, full code high unless the frequency code is zero
    wire logic high = freq_ok && ((duty_r == animator_pkg::CODE_FULL) || (phase < duty_r));

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drive_low_r <= 1'b1;
        end else if (ce) begin
            drive_low_r <= !high; // [R02] [R03]
        end
    end

    assign duty = duty_r;
    assign drive_low = drive_low_r;
endmodule : fade_channel

// *** logic/fade_animator.sv ***
// Function
// R01 - Five-bit frequency code picks the PWM period; code zero gives no output.
// R02 - Duty equals code over 128 for codes 1 to 126.
// R03 - Code 0 holds low, code 127 holds high.
// R04 - Running duty code comes only from the sequencer, never from a port.
// R05 - Each channel brightens along a logarithmic curve while fading in.
// R06 - Mode pin high selects standalone and locks the register port.
// R07 - Standalone runs the animation from stored configuration alone.
// R08 - Mode pin low selects programming mode with the register port open.
// R09 - Pulse pins are open drain: they only ever pull low.
// R10 - All four pulse pins switch to PWM together.
// R11 - Sequence starts on trigger input or after power-up.
// R12 - Trigger output toggles so a following device can chain on.
// R13 - Each channel starts a delay after the one before it.
// R14 - First-channel wait before channel 0; shared wait before others and trigger.
// R15 - One fade step lasts 2.4 us times rate plus 5.6 us.
// R16 - A start delay is the wait count times the step time.
// R17 - Rate zero disables fading but delays use rate 256.
// R18 - No fade-out phase; ramps only go up.
// R19 - Ramp ends at the ceiling code.
// R20 - Ramp begins at the floor code.
// R21 - Value scaled by 32 grows by a 32nd per step; floor 0 acts as 1.
// R22 - Step timer restarts at each boundary, so start times do not drift.
module fade_animator (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ce,
    input wire logic mode_select,
    input wire logic trigger_input,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic prog_active,
    input wire logic [3:0] pulse_out_in,
    output logic [3:0] pulse_out_out,
    output logic [3:0] pulse_out_oe,
    output logic trigger_output
);
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_WAIT_FIRST = 4'h2,
        ST_WAIT_NEXT = 4'h4,
        ST_DONE = 4'h8
    } seq_e;

    animator_pkg::cfg_s cfg;
    seq_e state_r;
    seq_e state_nxt;
    logic mode_s1_r;
    logic mode_s2_r;
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_s3_r;
    logic boot_pending_r;
    logic prog_r;
    logic [11:0] tick_cnt_r;
    logic [6:0] phase_r;
    logic [23:0] step_cnt_r;
    logic [15:0] wait_cnt_r;
    logic [15:0] wait_nxt;
    logic [2:0] slot_r;
    logic [2:0] slot_nxt;
    logic [3:0] go;
    logic trig_flip;
    logic trigger_output_r;
    logic [3:0] oe_r;
    logic [3:0] out_r;
    logic [3:0] drive_low;
    logic [6:0] duty [4];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_s1_r <= 1'b0;
            mode_s2_r <= 1'b0;
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_s3_r <= 1'b0;
        end else if (ce) begin
            mode_s1_r <= mode_select;
            mode_s2_r <= mode_s1_r;
            trig_s1_r <= trigger_input;
            trig_s2_r <= trig_s1_r;
            trig_s3_r <= trig_s2_r;
        end
    end

    // Mode and start decode
    wire logic standalone = mode_s2_r; // [R06] [R08]
    wire logic trig_rise = trig_s2_r && !trig_s3_r;
    wire logic start = standalone && (boot_pending_r || trig_rise); // [R11]
    wire logic restart = start || !standalone;
    wire logic port_open = !standalone; // [R06] [R08]

    // ------------------------------------------------------------
    // Configuration storage
    // ------------------------------------------------------------
    config_store u_store (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .ce(ce),
        .wr_en(reg_wr && port_open),
        .rd_en(reg_rd && port_open),
        .addr(reg_addr),
        .wdata(reg_wdata),
        .rdata(reg_rdata),
        .cfg(cfg)
    );

    // ------------------------------------------------------------
    // PWM time base
    // ------------------------------------------------------------
    wire logic freq_ok = cfg.freq != 5'h00; // [R01]
    wire logic [11:0] tick_len = 12'(animator_pkg::freq_div(cfg.freq) *
        animator_pkg::PWM_TICK_CYC); // [R01]
    wire logic tick_end = (tick_cnt_r >= tick_len - 12'h001);

    // One phase step per tick, 128 phases per period
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt_r <= 12'h000;
            phase_r <= 7'h00;
        end else if (ce) begin
            tick_cnt_r <= tick_end ? 12'h000 : tick_cnt_r + 12'h001;
            phase_r <= tick_end ? phase_r + 7'h01 : phase_r; // [R02]
        end
    end

    // ------------------------------------------------------------
    // Fade step timer
    // ------------------------------------------------------------
    wire logic fade_on = cfg.rate != 16'h0000; // [R17]
    wire logic [23:0] step_len = animator_pkg::step_cycles(cfg.rate); // [R15] [R17]
    wire logic step = (step_cnt_r >= step_len - 24'h000001);

    // Restarts on every boundary and on every new sequence
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            step_cnt_r <= 24'h000000;
        end else if (ce) begin
            step_cnt_r <= (restart || step) ? 24'h000000 : step_cnt_r + 24'h000001; // [R22]
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    wire logic first_due = wait_cnt_r == cfg.first_wait; // [R14] [R16]
    wire logic next_due = wait_cnt_r == cfg.shared_wait; // [R14] [R16]

    // Next state, channel slot and wait count
    always_comb begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        wait_nxt = step ? wait_cnt_r + 16'h0001 : wait_cnt_r;
        go = 4'h0;
        trig_flip = 1'b0;
        if (restart) begin
            state_nxt = start ? ST_WAIT_FIRST : ST_IDLE;
            slot_nxt = 3'h0;
            wait_nxt = 16'h0000;
        end else begin
            case (state_r)
                ST_WAIT_FIRST: begin
                    if (first_due) begin
                        go[0] = 1'b1; // [R13] [R14]
                        slot_nxt = 3'h1;
                        wait_nxt = 16'h0000;
                        state_nxt = ST_WAIT_NEXT;
                    end
                end
                ST_WAIT_NEXT: begin
                    if (next_due && slot_r == animator_pkg::TRIG_SLOT) begin
                        trig_flip = 1'b1; // [R12] [R14]
                        state_nxt = ST_DONE;
                    end else if (next_due) begin
                        go[slot_r[1:0]] = 1'b1; // [R13]
                        slot_nxt = slot_r + 3'h1;
                        wait_nxt = 16'h0000;
                    end
                end
                default: begin
                    wait_nxt = 16'h0000;
                end
            endcase
        end
    end

    // Sequencer registers; power-up start is held until standalone
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            slot_r <= 3'h0;
            wait_cnt_r <= 16'h0000;
            boot_pending_r <= 1'b1;
            trigger_output_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            wait_cnt_r <= wait_nxt;
            boot_pending_r <= boot_pending_r && !start; // [R11]
            trigger_output_r <= trigger_output_r ^ trig_flip; // [R12]
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    for (genvar i = 0; i < 4; i++) begin : g_chan
        fade_channel u_chan (
            .clk_sys(clk_sys),
            .arst_n(arst_n),
            .ce(ce),
            .restart(restart),
            .go(go[i]),
            .step(step),
            .fade_on(fade_on),
            .freq_ok(freq_ok),
            .floor(cfg.floor),
            .ceiling(cfg.ceiling),
            .phase(phase_r),
            .duty(duty[i]),
            .drive_low(drive_low[i])
        );
    end

    // Open-drain pins, all four switched by standalone mode together
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            oe_r <= 4'h0;
            out_r <= 4'h0;
            prog_r <= 1'b1;
        end else if (ce) begin
            oe_r <= standalone ? drive_low : 4'h0; // [R09] [R10] [R07]
            out_r <= 4'h0; // [R09]
            prog_r <= port_open;
        end
    end

    assign pulse_out_out = out_r;
    assign pulse_out_oe = oe_r;
    assign trigger_output = trigger_output_r;
    assign prog_active = prog_r;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_last_slot_due;
        ce && !restart && state_r == ST_WAIT_NEXT && slot_r == animator_pkg::TRIG_SLOT
            && next_due;
    endsequence

    sequence s_ch0_go;
        ce && go[0] && fade_on && cfg.floor != 7'h00 && cfg.floor <= cfg.ceiling;
    endsequence

    a_pins_only_low: assert property (pulse_out_out == 4'h0) // [R09]
        else $error("pulse pin driven high");

    a_prog_pins_free: assert property (ce && !standalone |=> pulse_out_oe == 4'h0) // [R10]
        else $error("pulse pin driven in programming mode");

    a_zero_code_low: assert property (ce && $past(ce) && duty[1] == 7'h00 && $stable(duty[1])
        |=> ce |-> pulse_out_oe[1] == $past(standalone)) // [R03]
        else $error("code zero not held low");

    a_full_code_high: assert property (ce && duty[2] == animator_pkg::CODE_FULL && freq_ok
        ##1 ce && standalone |=> ce |-> !pulse_out_oe[2]) // [R03]
        else $error("full code not held high");

    a_bad_freq_low: assert property (ce && !freq_ok ##1 ce && !freq_ok
        ##1 ce && standalone |=> pulse_out_oe == 4'hf) // [R01]
        else $error("invalid frequency code drives output");

    a_port_locked: assert property (ce && standalone && reg_wr |=> $stable(cfg)) // [R06]
        else $error("write taken in standalone mode");

    a_boot_start: assert property (ce && boot_pending_r && standalone
        |=> state_r == ST_WAIT_FIRST && !boot_pending_r) // [R11]
        else $error("power-up start missed");

    a_trig_toggles: assert property (s_last_slot_due
        |=> trigger_output != $past(trigger_output) && state_r == ST_DONE) // [R12] [R14]
        else $error("trigger output did not toggle");

    a_floor_start: assert property (s_ch0_go |=> duty[0] == $past(cfg.floor)) // [R20]
        else $error("ramp does not begin at floor");

    a_ceiling_cap: assert property (ce && go[3] ##1 (ce && !restart) [*8]
        |-> duty[3] <= cfg.ceiling) // [R19]
        else $error("ramp exceeds ceiling");

    a_ramp_rises: assert property (ce && !restart && $stable(cfg.ceiling)
        && !go[0] |=> duty[0] >= $past(duty[0]) || restart) // [R05] [R18] [R21]
        else $error("ramp went down");

    a_step_spacing: assert property (ce && step && !restart
        |=> step_cnt_r == 24'h000000) // [R15] [R22]
        else $error("step timer not restarted at boundary");

    a_wait_counts: assert property (ce && !restart && state_r == ST_WAIT_FIRST
        && !first_due && step |=> wait_cnt_r == $past(wait_cnt_r) + 16'h0001) // [R16]
        else $error("delay count not advanced by step");

endmodule : fade_animator

// *** testbench/pin_partner.sv ***
module pin_partner (
    input wire logic [3:0] drive_low,
    input wire logic [3:0] out_lvl,
    input wire logic trig,
    output logic [3:0] pin,
    output int chain_edges
);
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // LED lines and a following chained device
    // ------------------------------------------------------------
    // Pull-ups lift every pin that is not pulled low
    assign pin = ~drive_low | out_lvl;

    // Following device sees each toggle of the chain line
    initial chain_edges = 0;
    always @(trig) chain_edges++;
endmodule : pin_partner

// *** testbench/fade_animator_test.sv ***
module fade_animator_test;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys, arst_n, mode_select, trigger_input, reg_wr, reg_rd, prog_active;
    logic trigger_output;
    logic [6:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd_val;
    logic [3:0] pins, p_out, p_oe;
    int mismatches = 0, comparisons = 0, cyc_cnt = 0, edges, e0, t_prev, t_now, high, d, f;
    int fc [4] = '{1, 5, 7, 0};
    logic [6:0] addr_t [11] = '{7'h03, 7'h15, 7'h1f, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24,
        7'h25, 7'h27, 7'h26};
    logic [15:0] rst_t [11] = '{16'h0400, 16'h0407, 16'h13f9, 16'h0000, 16'hfe00, 16'h0000,
        16'h0000, 16'h0000, 16'h0000, 16'h0003, 16'h0000};

    fade_animator u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(1'b1),
        .mode_select(mode_select), .trigger_input(trigger_input), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .prog_active(prog_active), .pulse_out_in(pins), .pulse_out_out(p_out),
        .pulse_out_oe(p_oe), .trigger_output(trigger_output));
    pin_partner u_pins (.drive_low(p_oe), .out_lvl(p_out), .trig(trigger_output),
        .pin(pins), .chain_edges(edges));

    // ------------------------------------------------------------
    // Clock, cycle count and helpers
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) cyc_cnt <= cyc_cnt + 1;

    // Expected cycles of one fade step and tick divider per frequency code
    function automatic int step_of(input int r);
        return ((r == 0) ? 256 : r) * 240 + 560;
    endfunction : step_of
    function automatic int div_of(input int c);
        if (c <= 4) return c;
        if (c == 5) return 6;
        if (c == 6) return 8;
        if (c == 31) return 224;
        return 8 * (c - 5);
    endfunction : div_of

    task automatic test_done();
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic wr(input logic [6:0] a, input logic [15:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        cyc(1);
        reg_wr = 1'b0;
        cyc(1);
    endtask : wr

    task automatic rd(input logic [6:0] a);
        reg_addr = a;
        reg_rd = 1'b1;
        cyc(1);
        reg_rd = 1'b0;
        rd_val = reg_rdata;
        cyc(1);
    endtask : rd

    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: word %h, expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_count(input int got, input int exp, input int tol);
        comparisons++;
        if (got < exp - tol || got > exp + tol) begin
            mismatches++;
            $display("Error at %0t: count %0d, expected %0d", $time, got, exp);
        end
    endtask : cmp_count

    // Bounded wait for a pin to go high (index 4: chain line toggles)
    task automatic wait_until(input int i);
        int n;
        n = 0;
        while ((i < 4) ? (pins[i] !== 1'b1) : (edges == e0)) begin
            cyc(1);
            n++;
            if (n > 5000) begin
                mismatches++;
                $display("Error at %0t: wait on output %0d ran out", $time, i);
                test_done();
            end
        end
        t_now = cyc_cnt;
    endtask : wait_until

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        arst_n = 1'b0;
        mode_select = 1'b0;
        trigger_input = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
        d = $urandom(32'he8ee);
        cyc(3);
        arst_n = 1'b1;
        for (int k = 0; k < 11; k++) begin
            rd(addr_t[k]);
            cmp_word(rd_val, rst_t[k]);
        end
        for (int k = 0; k < 3; k++) begin
            d = $urandom;
            wr(7'h23 + 7'(k), 16'(d));
            rd(7'h23 + 7'(k));
            cmp_word(rd_val, 16'(d));
        end
        $display("Test 1 registers done");
        wr(7'h20, 16'hfe00);
        wr(7'h21, 16'hfe00);
        wr(7'h22, 16'h0080);
        wr(7'h23, 16'h0001);
        wr(7'h24, 16'h0002);
        wr(7'h25, 16'h0003);
        cmp_word({15'h0000, prog_active}, 16'h0001);
        mode_select = 1'b1;
        t_prev = cyc_cnt;
        cyc(4);
        cmp_word({15'h0000, prog_active}, 16'h0000);
        cmp_word({12'h000, pins}, 16'h0000);
        wr(7'h23, 16'h0005);
        e0 = edges;
        wait_until(0);
        cmp_count(t_now - t_prev, 2 * step_of(1) + 5, 5);
        for (int i = 1; i < 5; i++) begin
            t_prev = t_now;
            wait_until(i);
            cmp_count(t_now - t_prev, 3 * step_of(1), 3);
        end
        mode_select = 1'b0;
        cyc(4);
        rd(7'h23);
        cmp_word(rd_val, 16'h0001);
        $display("Test 2 cascade done");
        for (int k = 0; k < 4; k++) begin
            d = 1 + $urandom_range(125);
            f = fc[k];
            wr(7'h20, 16'(d << 9));
            wr(7'h21, 16'(d << 9));
            wr(7'h22, 16'(f << 7));
            wr(7'h23, (k == 2) ? 16'h0000 : 16'h0001);
            wr(7'h24, 16'h0000);
            wr(7'h25, 16'h0000);
            mode_select = 1'b1;
            e0 = edges;
            cyc(4);
            trigger_input = 1'b1;
            cyc(4);
            trigger_input = 1'b0;
            cyc(300);
            high = 0;
            repeat (2048 * ((f == 0) ? 1 : div_of(f))) begin
                if (pins[0] === 1'b1) high++;
                cyc(1);
            end
            cmp_count(high, d * 16 * div_of(f), 0);
            cmp_count(edges - e0, 1, 0);
            cmp_word({12'h000, p_out}, 16'h0000);
            mode_select = 1'b0;
            cyc(4);
        end
        $display("Test 3 frequency and duty done");
        test_done();
    end
endmodule : fade_animator_test
